// ### core/pic_arbiter.sv
`timescale 1ns/1ps
module pic_arbiter
	import pic_pkg::*;
(
	// Per-source state
	input  wire logic [NUM_SRC-1:0]   req_i,
	input  wire logic [NUM_SRC-1:0]   en_i,
	input  wire logic [NUM_SRC*3-1:0] pri_i,
	// Threshold
	input  wire logic [3:0]           level_i,
	input  wire logic                 tmp_dis_i,
	// Winner
	output logic                      win_valid,
	output logic [5:0]                win_id,
	output logic [2:0]                win_pri
);
	// Highest priority wins; lowest number wins ties
	always_comb begin
		logic [2:0] p;
		p = 3'h0;
		win_valid = 1'b0;
		win_id    = 6'h00;
		win_pri   = 3'h0;
		for (int i = NUM_SRC-1; i >= 0; i--) begin
			p = pri_i[i*3 +: 3];
			if (req_i[i] && en_i[i] && p != 3'h0
				&& {1'b0, p} > level_i
				&& !(tmp_dis_i && p <= PRI_TMP_BLOCK_MAX)
				&& (!win_valid || p >= win_pri)) begin
				win_valid = 1'b1;
				win_id    = 6'(i);
				win_pri   = p;
			end
		end
	end
endmodule : pic_arbiter

// ### core/pic_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Arbitrate 41 sources plus 4 traps
// - Flags set regardless of enable
// - Hardware sets, only software clears flags
// - Disabled source is never forwarded
// - Priority 1 lowest, 7 highest
// - Priority zero acts as disabled
// - CPU level is four bits
// - Nesting disable blocks new maskable interrupts while one is served
// - Nesting disable makes level read-only
// - Temporary disable blocks levels six down
// - Vector word read at the vector address goes to program counter
// - 63 vectors from 0x04 to 0xfe
// - Fetch from vector space traps
// - Jump into vector space traps
// - Trap control holds trap flags
// - External control selects table, edges
// - Three-bit field per nibble, top zero
// - Lower number wins equal priority
module pic_ctrl
	import pic_pkg::*;
(
	// APB
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	// Interrupt sources
	input  wire logic [NUM_SRC-1:0]  src_evt,
	input  wire logic [4:0]          ext_pin,
	input  wire logic [NUM_TRAP-1:0] trap_evt,
	// Core side
	input  wire logic              in_service,
	input  wire logic              ack,
	input  wire logic              ret,
	input  wire logic [3:0]        prev_level,
	input  wire logic              instr_done,
	input  wire logic              temporary_disable_start,
	input  wire logic [13:0]       temporary_disable_count,
	input  wire logic [23:0]       vec_data,
	input  wire logic              fetch_valid,
	input  wire logic [23:0]       fetch_addr,
	input  wire logic              jump_valid,
	input  wire logic [23:0]       jump_target,
	input  wire logic              vector_fetch,
	output logic                   irq_req,
	output logic [5:0]             irq_vector,
	output logic [23:0]            vec_addr,
	output logic [23:0]            pc_load,
	output logic                   pc_load_en,
	output logic [3:0]             cpu_priority_level
);
	////////////////////////////////////////////////////////////////////////////
	logic [47:0]           flags_r;     // Request flags, three words
	logic [47:0]           enables_r;   // Enable bits, three words
	logic [NUM_SRC*3-1:0]  pri_r;       // Priority fields packed
	logic [15:0]           trap_ctl_r;  // Trap control
	logic [15:0]           ext_ctl_r;   // External control
	logic [3:0]            level_r;     // CPU priority level
	logic [13:0]           temporary_disable_r;      // Temporary disable countdown
	logic [NUM_TRAP-1:0]   trap_pend_r; // Latched traps
	logic [4:0]            ext_s1_r;    // Pin sync stage one
	logic [4:0]            ext_s2_r;    // Pin sync stage two
	logic [4:0]            ext_s3_r;    // Pin previous value
	logic                  wr;          // Write strobe
	logic [NUM_SRC-1:0]    hw_set;      // Flag set events
	logic                  win_valid;   // Arbiter has winner
	logic [5:0]            win_id;      // Winning source
	logic [2:0]            win_pri;     // Winning priority
	logic                  addr_err;    // Vector space hit
	logic                  tmp_dis;     // Temporary disable active
	logic [1:0]            trap_idx;    // Highest trap
	logic                  trap_any;    // Any trap pending
	logic [6:0]            vec_slot;    // Table slot of the request
	logic [23:0]           vec_base;    // Base of the selected table

	// Decode a word offset within a bank
	// Word index counts in four-byte steps
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base,
		input int idx);
		hit = (a == base + ADDR_W'(idx*4));
	endfunction : hit

	assign wr      = psel && penable && pwrite;
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign tmp_dis = temporary_disable_r != 14'h0000;
	assign cpu_priority_level = level_r;

	////////////////////////////////////////////////////////////////////////////
	// External pins synchronised, rising or falling edge per polarity bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_s1_r <= 5'h00;
			ext_s2_r <= 5'h00;
			ext_s3_r <= 5'h00;
		end else begin
			ext_s1_r <= ext_pin;
			ext_s2_r <= ext_s1_r;
			// Third stage only keeps the last value for edge detection
			ext_s3_r <= ext_s2_r;
		end
	end

	// Map events onto sources; pins 0..4 drive the external slots
	always_comb begin
		hw_set = src_evt;
		// Polarity bit high selects the falling edge
		for (int k = 0; k < 5; k++) begin
			if (ext_ctl_r[k] ? (ext_s3_r[k] && !ext_s2_r[k])
				: (!ext_s3_r[k] && ext_s2_r[k]))
				hw_set[k] = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Request flags: hardware sets win over software clears
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_r <= 48'h0;
		end else begin
			for (int w = 0; w < 3; w++) begin
				// Whole-word software write first
				if (wr && hit(paddr, OFF_FLAGS0, w))
					flags_r[w*16 +: 16] <= pwdata[15:0];
			end
			// Hardware events last so a same-cycle set wins
			for (int i = 0; i < NUM_SRC; i++) begin
				if (hw_set[i])
					flags_r[i] <= 1'b1;
			end
			flags_r[47:NUM_SRC] <= '0;
		end
	end

	// Enable bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enables_r <= 48'h0;
		end else begin
			for (int w = 0; w < 3; w++) begin
				if (wr && hit(paddr, OFF_ENABLE0, w))
					enables_r[w*16 +: 16] <= pwdata[15:0];
			end
			enables_r[47:NUM_SRC] <= '0;
		end
	end

	// Priority fields, four per register, top bit of each nibble dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pri_r <= '0;
		end else begin
			for (int i = 0; i < NUM_SRC; i++) begin
				if (wr && hit(paddr, OFF_PRI0, i/4))
					pri_r[i*3 +: 3] <= pwdata[(i%4)*4 +: 3];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Trap control: nesting disable plus sticky trap flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trap_ctl_r <= RST_REG16;
		end else begin
			// Writing zero clears a trap flag, one keeps it
			if (wr && hit(paddr, OFF_TRAPCTL, 0)) begin
				trap_ctl_r[BIT_NEST_DIS]    <= pwdata[BIT_NEST_DIS];
				trap_ctl_r[NUM_TRAP-1:0]    <= trap_ctl_r[NUM_TRAP-1:0] & pwdata[NUM_TRAP-1:0];
			end
			// Events follow the write so a same-cycle set wins
			for (int t = 0; t < NUM_TRAP; t++) begin
				if (trap_evt[t] || (t == BIT_ADDR_ERR && addr_err))
					trap_ctl_r[t] <= 1'b1;
			end
		end
	end

	// External control: edge polarity and alternate table select
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_ctl_r <= RST_REG16;
		end else if (wr && hit(paddr, OFF_EXTCTL, 0)) begin
			ext_ctl_r[4:0]         <= pwdata[4:0];
			ext_ctl_r[BIT_ALT_VEC] <= pwdata[BIT_ALT_VEC];
		end
	end

	// CPU level: software write unless locked, core updates on take and return
	// A take outranks a return, and both outrank software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_r <= RST_CPUPRI;
		end else if (ack && trap_any) begin
			level_r <= 4'h8; // Traps run above every maskable level
		end else if (ack && win_valid) begin
			level_r <= {1'b0, win_pri};
		end else if (ret) begin
			level_r <= prev_level;
		end else if (wr && hit(paddr, OFF_CPUPRI, 0) && !trap_ctl_r[BIT_NEST_DIS]) begin
			level_r <= pwdata[3:0];
		end
	end

	// Temporary disable counts down one per completed instruction
	// A reload wins over a count in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			temporary_disable_r <= 14'h0000;
		end else if (temporary_disable_start) begin
			temporary_disable_r <= temporary_disable_count;
		end else if (instr_done && tmp_dis) begin
			temporary_disable_r <= temporary_disable_r - 14'h0001;
		end
	end

	// Latched traps, cleared when taken
	// A new event outranks the clear of a taken trap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trap_pend_r <= '0;
		end else begin
			for (int t = 0; t < NUM_TRAP; t++) begin
				if (trap_evt[t] || (t == BIT_ADDR_ERR && addr_err))
					trap_pend_r[t] <= 1'b1;
				else if (ack && trap_any && trap_idx == 2'(t))
					trap_pend_r[t] <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	pic_arbiter u_arb (
		.req_i     (flags_r[NUM_SRC-1:0]),
		.en_i      (enables_r[NUM_SRC-1:0]),
		.pri_i     (pri_r),
		.level_i   (level_r),
		.tmp_dis_i (tmp_dis),
		.win_valid (win_valid),
		.win_id    (win_id),
		.win_pri   (win_pri)
	);

	pic_vecguard u_guard (
		.fetch_valid  (fetch_valid),
		.fetch_addr   (fetch_addr),
		.jump_valid   (jump_valid),
		.jump_target  (jump_target),
		.vector_fetch (vector_fetch),
		.addr_err     (addr_err)
	);

	// Lowest numbered trap pending wins
	always_comb begin
		trap_idx = 2'h0;
		trap_any = 1'b0;
		for (int t = NUM_TRAP-1; t >= 0; t--) begin
			if (trap_pend_r[t]) begin
				trap_idx = 2'(t);
				trap_any = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Table slot: traps take 0..3, sources follow from 4
	always_comb begin
		if (trap_any) begin
			vec_slot = {5'h00, trap_idx};
		end else begin
			vec_slot = 7'(win_id) + 7'h04;
		end
	end

	// One two-address word per slot; the alternate table lies above
	assign vec_base = ext_ctl_r[BIT_ALT_VEC] ? ALT_BASE : VEC_LO;

	// Request to core; traps ahead of maskable sources
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_req    <= 1'b0;
			irq_vector <= 6'h00;
			vec_addr   <= 24'h0;
		end else begin
			// Nesting disable holds maskable requests off while one is served
			irq_req <= trap_any
				|| (win_valid && !(trap_ctl_r[BIT_NEST_DIS] && in_service));
			// Trap vectors first at 1..4, sources follow from 8
			irq_vector <= trap_any ? {4'h0, trap_idx} + 6'h01 : win_id + 6'h08;
			vec_addr   <= vec_base + {16'h0000, vec_slot, 1'b0};
		end
	end

	// Vector word from program bus goes straight to the counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_load    <= 24'h0;
			pc_load_en <= 1'b0;
		end else begin
			pc_load_en <= ack;
			if (ack)
				pc_load <= vec_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read mux; unmapped reads zero
	always_comb begin
		prdata = 32'h0;
		// Flag and enable words
		for (int w = 0; w < 3; w++) begin
			if (hit(paddr, OFF_FLAGS0, w))
				prdata[15:0] = flags_r[w*16 +: 16];
			if (hit(paddr, OFF_ENABLE0, w))
				prdata[15:0] = enables_r[w*16 +: 16];
		end
		// Priority nibbles, spare top bit reads zero
		for (int i = 0; i < NUM_SRC; i++) begin
			if (hit(paddr, OFF_PRI0, i/4))
				prdata[(i%4)*4 +: 3] = pri_r[i*3 +: 3];
		end
		// Control words; the temporary disable status is live
		if (hit(paddr, OFF_TRAPCTL, 0))
			prdata[15:0] = trap_ctl_r;
		if (hit(paddr, OFF_EXTCTL, 0)) begin
			prdata[15:0]        = ext_ctl_r;
			prdata[BIT_TMP_DIS] = tmp_dis;
		end
		// Level, winner and countdown for software
		if (hit(paddr, OFF_CPUPRI, 0))
			prdata[3:0] = level_r;
		if (hit(paddr, OFF_VECSEL, 0))
			prdata[6:0] = {win_valid, win_id};
		if (hit(paddr, OFF_DISCNT, 0))
			prdata[13:0] = temporary_disable_r;
	end
endmodule : pic_ctrl

// ### core/pic_pkg.sv
package pic_pkg;
	// Source counts
	localparam int NUM_SRC      = 41;
	localparam int NUM_TRAP     = 4;
	localparam int NUM_VEC      = 63;
	localparam int NUM_PRI_REG  = 11;
	localparam int ADDR_W       = 8;
	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFF_FLAGS0  = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_ENABLE0 = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_PRI0    = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_TRAPCTL = 8'h44;
	localparam logic [ADDR_W-1:0] OFF_EXTCTL  = 8'h48;
	localparam logic [ADDR_W-1:0] OFF_CPUPRI  = 8'h4c;
	localparam logic [ADDR_W-1:0] OFF_VECSEL  = 8'h50;
	localparam logic [ADDR_W-1:0] OFF_DISCNT  = 8'h54;
	// Field positions
	localparam int BIT_NEST_DIS = 15;
	localparam int BIT_TMP_DIS  = 14;
	localparam int BIT_ALT_VEC  = 15;
	localparam int BIT_ADDR_ERR = 3;
	// Priority thresholds
	localparam logic [2:0] PRI_TMP_BLOCK_MAX = 3'h6;
	// Reset values
	localparam logic [15:0] RST_REG16  = 16'h0000;
	localparam logic [3:0]  RST_CPUPRI = 4'h0;
	// Vector space in program memory
	localparam logic [23:0] VEC_LO   = 24'h000004;
	localparam logic [23:0] VEC_HI   = 24'h0000fe;
	localparam logic [23:0] ALT_BASE = 24'h000080;
	localparam logic [7:0]  NO_WIN   = 8'hff;
endpackage : pic_pkg

// ### core/pic_vecguard.sv
`timescale 1ns/1ps
module pic_vecguard
	import pic_pkg::*;
(
	// Fetch snoop
	input  wire logic        fetch_valid,
	input  wire logic [23:0] fetch_addr,
	input  wire logic        jump_valid,
	input  wire logic [23:0] jump_target,
	input  wire logic        vector_fetch,
	// Hit
	output logic             addr_err
);
	// Any non-vector fetch or jump into vector space traps
	always_comb begin
		addr_err = 1'b0;
		if (fetch_valid && !vector_fetch && fetch_addr >= VEC_LO && fetch_addr <= VEC_HI)
			addr_err = 1'b1;
		if (jump_valid && jump_target >= VEC_LO && jump_target <= VEC_HI)
			addr_err = 1'b1;
	end
endmodule : pic_vecguard

// ### verification/pic_core_model.sv
`timescale 1ns/1ps
module pic_core_model
	import pic_pkg::*;
(
	// Clock and pace
	input wire logic         pclk,
	input wire logic         presetn,
	input wire logic         slow,
	// From controller
	input wire logic         irq_req,
	input wire logic [23:0]  vec_addr,
	input wire logic [3:0]   cpu_priority_level,
	// To controller
	output logic             ack,
	output logic             in_service,
	output logic             ret,
	output logic [3:0]       prev_level,
	output logic [23:0]      vec_data
);
	logic [3:0] wait_r; // Service or gap countdown
	// Program memory word stored at each vector slot
	assign vec_data = {vec_addr[15:0], 8'ha5};
	////////////////////////////////////////////////////////////////
	// Take, serve for a while, then return
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{ack, in_service, ret, prev_level, wait_r} <= '0;
		end else begin
			ack <= 1'b0;
			ret <= 1'b0;
			if (wait_r != 4'h0) begin // Busy or settling
				wait_r <= wait_r - 4'h1;
			end else if (in_service) begin // Service done
				ret <= 1'b1;
				in_service <= 1'b0;
				wait_r <= 4'h3;
			end else if (irq_req) begin // Take request
				ack <= 1'b1;
				in_service <= 1'b1;
				prev_level <= cpu_priority_level;
				wait_r <= slow ? 4'hf : 4'h4;
			end
		end
	end
endmodule : pic_core_model

// ### verification/pic_monitor.sv
`timescale 1ns/1ps
module pic_monitor
	import pic_pkg::*;
(
	// Clock and reset
	input wire logic              pclk,
	input wire logic              presetn,
	// Register bus
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic              pready,
	input wire logic [31:0]       prdata,
	input wire logic              pslverr,
	// Core side
	input wire logic              ack,
	input wire logic              ret,
	input wire logic [3:0]        prev_level,
	input wire logic [23:0]       vec_data,
	input wire logic              irq_req,
	input wire logic [23:0]       vec_addr,
	input wire logic [23:0]       pc_load,
	input wire logic              pc_load_en,
	input wire logic [3:0]        cpu_priority_level
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////
	// Core takes the request
	sequence s_take;
		ack;
	endsequence
	// Vector word lands in the counter
	sequence s_load(logic [23:0] w);
		pc_load_en && pc_load == w;
	endsequence
	load_vec_a: assert property (s_take |=> s_load($past(vec_data)))
		else $error("vector word not loaded");
	load_cause_a: assert property (pc_load_en |-> $past(ack))
		else $error("counter load without take");
	vec_range_a: assert property (irq_req |-> vec_addr >= VEC_LO && vec_addr <= VEC_HI)
		else $error("vector address outside table");
	take_up_a: assert property (s_take |=> cpu_priority_level > $past(cpu_priority_level))
		else $error("taken level not above old level");
	level_ret_a: assert property (ret |=> cpu_priority_level == $past(prev_level))
		else $error("level not restored on return");
	level_cause_a: assert property (!$stable(cpu_priority_level) |->
		$past(ack || ret || (psel && penable && pwrite)))
		else $error("level changed without cause");
	bus_ok_a: assert property (psel && penable |-> pready && !pslverr)
		else $error("bus access stalled or errored");
	unmapped_a: assert property (psel && !pwrite && paddr >= 8'h58 |-> prdata == 32'h0)
		else $error("unmapped read not zero");
endmodule : pic_monitor
bind pic_ctrl pic_monitor pic_monitor_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pready, .prdata, .pslverr, .ack, .ret, .prev_level, .vec_data, .irq_req, .vec_addr,
	.pc_load, .pc_load_en, .cpu_priority_level);

// ### verification/tb_prioritized_interrupt_controller.sv
`timescale 1ns/1ps
module tb_prioritized_interrupt_controller
	import pic_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
	logic in_service, ack, ret, instr_done, temporary_disable_start, fetch_valid, jump_valid, vector_fetch;
	logic irq_req, pc_load_en;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [NUM_SRC-1:0] src_evt;
	logic [4:0] ext_pin;
	logic [NUM_TRAP-1:0] trap_evt;
	logic [3:0] prev_level, cpu_priority_level;
	logic [13:0] temporary_disable_count;
	logic [5:0] irq_vector;
	logic [23:0] vec_data, fetch_addr, jump_target, vec_addr, pc_load;
	logic [31:0] rd_q[$], ld_q[$]; // Expected reads and loads
	logic [15:0] rnd;
	int n_mismatch, checks_done, seed, i;
	logic [7:0] ra[7] = '{8'h00, 8'h0c, 8'h18, 8'h44, 8'h48, 8'h4c, 8'h58};
	pic_ctrl pic_ctrl_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
		.prdata, .pslverr, .src_evt, .ext_pin, .trap_evt, .in_service, .ack, .ret, .prev_level,
		.instr_done, .temporary_disable_start, .temporary_disable_count, .vec_data, .fetch_valid, .fetch_addr, .jump_valid,
		.jump_target, .vector_fetch, .irq_req, .irq_vector, .vec_addr, .pc_load, .pc_load_en,
		.cpu_priority_level);
	pic_core_model pic_core_model_inst (.pclk, .presetn, .slow, .irq_req, .vec_addr,
		.cpu_priority_level, .ack, .in_service, .ret, .prev_level, .vec_data);
	////////////////////////////////////////////////////////////////
	task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : check
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim
	// One bus transfer, setup then access until ready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (!pready);
		{psel, penable} <= 2'b00;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask : rd
	task automatic at(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : at
	task automatic evt(input logic [NUM_SRC-1:0] m);
		@(posedge pclk);
		src_evt <= m;
		@(posedge pclk);
		src_evt <= '0;
	endtask : evt
	// Expected counter word for a vector slot
	function automatic logic [31:0] lw(input int s);
		logic [23:0] a;
		a = VEC_LO + 24'(2 * s);
		return {8'h00, a[15:0], 8'ha5};
	endfunction : lw
	////////////////////////////////////////////////////////////////
	// Clock
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// Result watcher
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) check("prdata", prdata, rd_q.pop_front());
		if (pc_load_en) check("pc_load", 32'(pc_load), ld_q.pop_front());
	end
	// Watchdog
	initial begin
		repeat (3000) @(posedge pclk);
		n_mismatch++;
		end_sim();
	end
	// Main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata, src_evt, ext_pin, trap_evt} = '0;
		{instr_done, temporary_disable_start, temporary_disable_count, fetch_valid, jump_valid, vector_fetch} = '0;
		{fetch_addr, jump_target} = '0;
		{slow, presetn, seed} = {1'b1, 1'b0, 32'd30};
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, 8'h58, 32'hffff);
		foreach (ra[k]) rd(ra[k], 32'h0);
		evt(41'h8);
		rd(OFF_FLAGS0, 32'h8);
		apb(1'b1, OFF_ENABLE0, 32'h8);
		at(3);
		check("irq_req", 32'(irq_req), 32'h0);
		ld_q.push_back(lw(7));
		apb(1'b1, OFF_PRI0, 32'h5000);
		at(4);
		check("level", 32'(cpu_priority_level), 32'h5);
		rd(OFF_FLAGS0, 32'h8);
		apb(1'b1, OFF_FLAGS0, 32'h0);
		at(20);
		check("level", 32'(cpu_priority_level), 32'h0);
		apb(1'b1, OFF_CPUPRI, 32'h5);
		apb(1'b1, OFF_PRI0, 32'h5050);
		apb(1'b1, OFF_FLAGS0, 32'h0);
		apb(1'b1, OFF_ENABLE0, 32'ha);
		evt(41'ha);
		at(3);
		check("irq_req", 32'(irq_req), 32'h0);
		ld_q.push_back(lw(5));
		apb(1'b1, OFF_CPUPRI, 32'h4);
		at(1);
		check("vec_addr", 32'(vec_addr), 32'he);
		check("irq_vector", 32'(irq_vector), 32'h9);
		apb(1'b1, OFF_FLAGS0, 32'h0);
		at(20);
		apb(1'b1, OFF_ENABLE0, 32'h0);
		apb(1'b1, OFF_TRAPCTL, 32'h800f);
		apb(1'b1, OFF_CPUPRI, 32'h2);
		rd(OFF_CPUPRI, 32'h4);
		apb(1'b1, OFF_TRAPCTL, 32'h0);
		apb(1'b1, OFF_CPUPRI, 32'h0);
		for (i = 0; i < 3; i++) begin
			if (i < 2) ld_q.push_back(lw(3));
			@(posedge pclk);
			{fetch_valid, jump_valid, vector_fetch} <= {i != 1, i == 1, i == 2};
			{fetch_addr, jump_target} <= {24'h10, 24'h20};
			@(posedge pclk);
			{fetch_valid, jump_valid, vector_fetch} <= '0;
			at(4);
			rd(OFF_TRAPCTL, (i < 2) ? 32'h8 : 32'h0);
			apb(1'b1, OFF_TRAPCTL, 32'h0);
			at(20);
		end
		// Pin edge on source 0 held off by temporary disable, then served from the alternate table
		apb(1'b1, OFF_EXTCTL, 32'h8000);
		apb(1'b1, OFF_PRI0, 32'h0006);
		apb(1'b1, OFF_ENABLE0, 32'h1);
		@(posedge pclk);
		{temporary_disable_start, temporary_disable_count, ext_pin} <= {1'b1, 14'h2, 5'h01};
		@(posedge pclk);
		temporary_disable_start <= 1'b0;
		at(6);
		check("irq_req", 32'(irq_req), 32'h0);
		rd(OFF_FLAGS0, 32'h1);
		ld_q.push_back({8'h00, 16'(ALT_BASE + 24'h8), 8'ha5});
		repeat (2) begin
			@(posedge pclk);
			instr_done <= 1'b1;
			@(posedge pclk);
			instr_done <= 1'b0;
		end
		at(1);
		check("irq_req", 32'(irq_req), 32'h1);
		check("vec_addr", 32'(vec_addr), 32'h88);
		// Higher source while serving with nesting disabled: held off
		apb(1'b1, OFF_PRI0, 32'h0076);
		apb(1'b1, OFF_ENABLE0, 32'h3);
		apb(1'b1, OFF_TRAPCTL, 32'h8000);
		evt(41'h2);
		at(2);
		check("irq_req", 32'(irq_req), 32'h0);
		apb(1'b1, OFF_FLAGS0, 32'h0);
		at(20);
		apb(1'b1, OFF_TRAPCTL, 32'h0);
		apb(1'b1, OFF_EXTCTL, 32'h0);
		apb(1'b1, OFF_ENABLE0, 32'h0);
		@(posedge pclk);
		{temporary_disable_start, temporary_disable_count} <= {1'b1, 14'h2};
		@(posedge pclk);
		temporary_disable_start <= 1'b0;
		rd(OFF_EXTCTL, 32'h4000);
		repeat (4) begin
			@(posedge pclk);
			instr_done <= 1'b1;
			@(posedge pclk);
			instr_done <= 1'b0;
		end
		rd(OFF_EXTCTL, 32'h0);
		rnd = 16'($random(seed));
		evt({25'h0, rnd});
		rd(OFF_FLAGS0, {16'h0, rnd});
		at(2);
		check("irq_req", 32'(irq_req), 32'h0);
		at(3);
		check("loads left", 32'(ld_q.size()), 32'h0);
		end_sim();
	end
endmodule : tb_prioritized_interrupt_controller
